// >>> crm_pkg.sv
// Constants, types and the state record of the CPU register model.
// Assumes a single 125 MHz clock and a synchronous active-high reset.
package crm_pkg;

   localparam logic [7:0] CRM_OFF_CMD = 8'h00;
   localparam logic [7:0] CRM_OFF_STAT = 8'h04;
   localparam logic [7:0] CRM_OFF_ACC = 8'h08;
   localparam logic [7:0] CRM_OFF_IDX = 8'h0C;
   localparam logic [7:0] CRM_OFF_STK = 8'h10;
   localparam logic [7:0] CRM_OFF_FLAG = 8'h14;

   localparam int CRM_F_C = 0;
   localparam int CRM_F_V = 1;
   localparam int CRM_F_Z = 2;
   localparam int CRM_F_N = 3;
   localparam int CRM_F_I = 4;
   localparam int CRM_F_H = 5;
   localparam int CRM_F_X = 6;
   localparam int CRM_F_S = 7;
   localparam logic [7:0] CRM_FLAG_RST = 8'hD0;

   localparam logic [15:0] CRM_VEC_NORM_POR = 16'hFFFE;
   localparam logic [15:0] CRM_VEC_NORM_CLKMON = 16'hFFFC;
   localparam logic [15:0] CRM_VEC_NORM_WDOG = 16'hFFFA;
   localparam logic [15:0] CRM_VEC_TEST_POR = 16'hBFFE;
   localparam logic [15:0] CRM_VEC_TEST_CLKMON = 16'hBFFC;
   localparam logic [15:0] CRM_VEC_TEST_WDOG = 16'hBFFA;

   localparam logic [3:0] CRM_LEN_BYTE = 4'h1;
   localparam logic [3:0] CRM_LEN_WORD = 4'h2;
   localparam logic [3:0] CRM_LEN_FRAME = 4'h9;

   localparam logic [1:0] CRM_RESP_OKAY = 2'h0;
   localparam logic [1:0] CRM_RESP_SLVERR = 2'h2;
   localparam logic [1:0] CRM_RESP_DECERR = 2'h3;

   typedef enum logic [1:0] {
      CRM_CAUSE_POR,
      CRM_CAUSE_CLKMON,
      CRM_CAUSE_WDOG
   } crm_cause_t;

   typedef enum logic [4:0] {
      CRM_OP_NOP, CRM_OP_LDA, CRM_OP_STAX, CRM_OP_STAY, CRM_OP_ADDA, CRM_OP_ADCA,
      CRM_OP_ABA, CRM_OP_CMPA, CRM_OP_ROLA, CRM_OP_MUL, CRM_OP_ABX, CRM_OP_ABY,
      CRM_OP_TAP, CRM_OP_TPA, CRM_OP_XGDX, CRM_OP_INX, CRM_OP_DEX, CRM_OP_INY,
      CRM_OP_DEY, CRM_OP_LDS, CRM_OP_LDX, CRM_OP_LDY, CRM_OP_PSHA, CRM_OP_PULA,
      CRM_OP_JSR, CRM_OP_BSR, CRM_OP_RTS, CRM_OP_IRQ, CRM_OP_NONMASKABLE_INTERRUPT_LINE, CRM_OP_RTI,
      CRM_OP_STOP
   } crm_op_t;

   typedef enum logic [2:0] {
      CRM_S_RST, CRM_S_VEC_HI, CRM_S_VEC_LO, CRM_S_IDLE, CRM_S_PUSH, CRM_S_PULL, CRM_S_STORE
   } crm_state_t;

   typedef struct packed {
      logic req;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } crm_mem_req_t;

   typedef struct packed {
      crm_state_t st;
      crm_op_t op;
      logic [7:0] accA;
      logic [7:0] accB;
      logic [15:0] idxOne;
      logic [15:0] idxTwo;
      logic [15:0] stackPtr;
      logic [15:0] progCnt;
      logic [7:0] flags;
      logic [15:0] effAddr;
      logic [71:0] frame;
      logic [3:0] cnt;
      logic [3:0] len;
      logic [15:0] vec;
      logic stopped;
      logic irqPend;
      logic [15:0] irqVec;
      logic xirqPend;
      logic [15:0] xirqVec;
      crm_mem_req_t mem;
      logic [7:0] awAddr;
      logic awHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic wHave;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } crm_state_rec_t;

endpackage

// >>> cpu_register_model.sv
// Programmer-visible CPU state driven by commands written over AXI4-Lite.
// Assumes a byte-wide memory that answers each request with a one-cycle memAck.
module cpu_register_model
   import crm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic bootMode,
   input wire crm_cause_t resetCause,
   output crm_mem_req_t memOut,
   input wire logic memAck,
   input wire logic [7:0] memRdata,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);

   crm_state_rec_t r;
   crm_state_rec_t n;
   logic go;
   crm_op_t cmdOp;
   logic [7:0] opByte;
   logic [15:0] opWord;

   function automatic logic [7:0] setNz(input logic [7:0] f, input logic neg, input logic zero);
      logic [7:0] g;
      g = f;
      g[CRM_F_N] = neg;
      g[CRM_F_Z] = zero;
      return g;
   endfunction

   assign cmdOp = crm_op_t'(r.wData[4:0]);
   assign opByte = r.wData[15:8];
   assign opWord = r.wData[31:16];
   assign awready = !r.awHave && !r.bValid;
   assign wready = !r.wHave && !r.bValid;
   assign arready = !r.rValid;
   assign bvalid = r.bValid;
   assign bresp = r.bResp;
   assign rvalid = r.rValid;
   assign rdata = r.rData;
   assign rresp = r.rResp;
   assign memOut = r.mem;

   always_comb begin
      logic [7:0] addOp;
      logic [8:0] sum9;
      logic [8:0] dif9;
      logic [15:0] prod;
      logic [15:0] base;
      logic [3:0] idx;
      n = r;
      go = 1'b0;
      addOp = (cmdOp == CRM_OP_ABA) ? r.accB : opByte;
      sum9 = {1'b0, r.accA} + {1'b0, addOp} + {8'h00, (cmdOp == CRM_OP_ADCA) & r.flags[CRM_F_C]};
      dif9 = {1'b0, r.accA} - {1'b0, opByte};
      prod = {8'h00, r.accA} * {8'h00, r.accB};
      base = 16'h0000;
      idx = r.cnt;

      if (awvalid && awready) begin
         n.awAddr = awaddr;
         n.awHave = 1'b1;
      end
      if (wvalid && wready) begin
         n.wData = wdata;
         n.wStrb = wstrb;
         n.wHave = 1'b1;
      end
      if (r.bValid && bready) begin
         n.bValid = 1'b0;
      end
      if (r.awHave && r.wHave) begin
         n.awHave = 1'b0;
         n.wHave = 1'b0;
         n.bValid = 1'b1;
         n.bResp = CRM_RESP_SLVERR;
         if ({r.awAddr[7:2], 2'b00} == CRM_OFF_CMD) begin
            if (r.st == CRM_S_IDLE && r.wStrb == 4'hF) begin
               go = 1'b1;
               n.bResp = CRM_RESP_OKAY;
            end
         end else if ({r.awAddr[7:2], 2'b00} > CRM_OFF_FLAG) begin
            n.bResp = CRM_RESP_DECERR;
         end
      end
      if (arvalid && arready) begin
         n.rValid = 1'b1;
         n.rResp = CRM_RESP_OKAY;
         unique case ({araddr[7:2], 2'b00})
            CRM_OFF_CMD: n.rData = r.wData;
            CRM_OFF_STAT: n.rData = {24'h0000_00, 1'b0, r.st, r.xirqPend, r.irqPend, r.stopped,
                                     r.st != CRM_S_IDLE};
            CRM_OFF_ACC: n.rData = {16'h0000, r.accA, r.accB};
            CRM_OFF_IDX: n.rData = {r.idxOne, r.idxTwo};
            CRM_OFF_STK: n.rData = {r.stackPtr, r.progCnt};
            CRM_OFF_FLAG: n.rData = {r.effAddr, 8'h00, r.flags};
            default: begin
               n.rData = 32'h0000_0000;
               n.rResp = CRM_RESP_DECERR;
            end
         endcase
      end else if (r.rValid && rready) begin
         n.rValid = 1'b0;
      end

      unique case (r.st)
         CRM_S_RST: begin
            // The mode and cause are sampled on the first edge after reset release.
            unique case (resetCause)
               CRM_CAUSE_CLKMON: base = bootMode ? CRM_VEC_TEST_CLKMON : CRM_VEC_NORM_CLKMON;
               CRM_CAUSE_WDOG: base = bootMode ? CRM_VEC_TEST_WDOG : CRM_VEC_NORM_WDOG;
               default: base = bootMode ? CRM_VEC_TEST_POR : CRM_VEC_NORM_POR;
            endcase
            n.mem = '{req: 1'b1, write: 1'b0, addr: base, wdata: 8'h00};
            n.st = CRM_S_VEC_HI;
         end
         CRM_S_VEC_HI: begin
            if (memAck) begin
               n.progCnt[15:8] = memRdata;
               n.mem.addr = r.mem.addr + 16'h0001;
               n.st = CRM_S_VEC_LO;
            end
         end
         CRM_S_VEC_LO: begin
            if (memAck) begin
               n.progCnt[7:0] = memRdata;
               n.mem.req = 1'b0;
               n.st = CRM_S_IDLE;
            end
         end
         CRM_S_IDLE: begin
            if (go) begin
               n.op = cmdOp;
               n.stopped = 1'b0;
               unique case (cmdOp)
                  CRM_OP_LDA: begin
                     n.accA = opByte;
                     n.flags = setNz(r.flags, opByte[7], opByte == 8'h00);
                     n.flags[CRM_F_V] = 1'b0;
                  end
                  CRM_OP_STAX, CRM_OP_STAY: begin
                     base = (cmdOp == CRM_OP_STAX) ? r.idxOne : r.idxTwo;
                     n.effAddr = base + {8'h00, opByte};
                     n.mem = '{req: 1'b1, write: 1'b1, addr: n.effAddr, wdata: r.accA};
                     n.flags = setNz(r.flags, r.accA[7], r.accA == 8'h00);
                     n.flags[CRM_F_V] = 1'b0;
                     n.st = CRM_S_STORE;
                  end
                  CRM_OP_ADDA, CRM_OP_ADCA, CRM_OP_ABA: begin
                     n.accA = sum9[7:0];
                     n.flags = setNz(r.flags, sum9[7], sum9[7:0] == 8'h00);
                     // The carry into bit 4 is bit 4 of the sum against bit 4 of both operands.
                     n.flags[CRM_F_H] = r.accA[4] ^ addOp[4] ^ sum9[4];
                     n.flags[CRM_F_V] = (r.accA[7] == addOp[7]) && (sum9[7] != r.accA[7]);
                     n.flags[CRM_F_C] = sum9[8];
                  end
                  CRM_OP_CMPA: begin
                     n.flags = setNz(r.flags, dif9[7], dif9[7:0] == 8'h00);
                     n.flags[CRM_F_V] = (r.accA[7] != opByte[7]) && (dif9[7] != r.accA[7]);
                     n.flags[CRM_F_C] = dif9[8];
                  end
                  CRM_OP_ROLA: begin
                     n.accA = {r.accA[6:0], r.flags[CRM_F_C]};
                     n.flags = setNz(r.flags, r.accA[6], n.accA == 8'h00);
                     n.flags[CRM_F_C] = r.accA[7];
                     n.flags[CRM_F_V] = r.accA[6] ^ r.accA[7];
                  end
                  CRM_OP_MUL: begin
                     {n.accA, n.accB} = prod;
                     n.flags[CRM_F_C] = prod[7];
                  end
                  CRM_OP_ABX: n.idxOne = r.idxOne + {8'h00, r.accB};
                  CRM_OP_ABY: n.idxTwo = r.idxTwo + {8'h00, r.accB};
                  CRM_OP_TAP: n.flags = {r.accA[7], r.accA[6] & r.flags[CRM_F_X], r.accA[5:0]};
                  CRM_OP_TPA: n.accA = r.flags;
                  CRM_OP_XGDX: {n.accA, n.accB, n.idxOne} = {r.idxOne, r.accA, r.accB};
                  CRM_OP_INX: n.idxOne = r.idxOne + 16'h0001;
                  CRM_OP_DEX: n.idxOne = r.idxOne - 16'h0001;
                  CRM_OP_INY: n.idxTwo = r.idxTwo + 16'h0001;
                  CRM_OP_DEY: n.idxTwo = r.idxTwo - 16'h0001;
                  CRM_OP_LDS, CRM_OP_LDX, CRM_OP_LDY: begin
                     if (cmdOp == CRM_OP_LDS) n.stackPtr = opWord;
                     if (cmdOp == CRM_OP_LDX) n.idxOne = opWord;
                     if (cmdOp == CRM_OP_LDY) n.idxTwo = opWord;
                     n.flags = setNz(r.flags, opWord[15], opWord == 16'h0000);
                     n.flags[CRM_F_V] = 1'b0;
                  end
                  CRM_OP_PSHA, CRM_OP_JSR, CRM_OP_BSR: begin
                     n.frame = (cmdOp == CRM_OP_PSHA) ? {64'h0, r.accA} : {56'h0, r.progCnt};
                     n.len = (cmdOp == CRM_OP_PSHA) ? CRM_LEN_BYTE : CRM_LEN_WORD;
                     n.cnt = 4'h0;
                     n.mem = '{req: 1'b1, write: 1'b1, addr: r.stackPtr, wdata: n.frame[7:0]};
                     if (cmdOp == CRM_OP_JSR) n.progCnt = opWord;
                     if (cmdOp == CRM_OP_BSR) n.progCnt = r.progCnt + {{8{opByte[7]}}, opByte};
                     n.st = CRM_S_PUSH;
                  end
                  CRM_OP_PULA, CRM_OP_RTS, CRM_OP_RTI: begin
                     n.len = (cmdOp == CRM_OP_PULA) ? CRM_LEN_BYTE
                           : (cmdOp == CRM_OP_RTS) ? CRM_LEN_WORD : CRM_LEN_FRAME;
                     n.cnt = n.len - 4'h1;
                     n.mem = '{req: 1'b1, write: 1'b0, addr: r.stackPtr + 16'h0001, wdata: 8'h00};
                     n.st = CRM_S_PULL;
                  end
                  CRM_OP_IRQ: begin
                     n.irqPend = 1'b1;
                     n.irqVec = opWord;
                  end
                  CRM_OP_NONMASKABLE_INTERRUPT_LINE: begin
                     n.xirqPend = 1'b1;
                     n.xirqVec = opWord;
                  end
                  CRM_OP_STOP: n.stopped = !r.flags[CRM_F_S];
                  default: n.op = CRM_OP_NOP;
               endcase
               // The index steps share one zero test so no other flag can move.
               if (cmdOp inside {CRM_OP_INX, CRM_OP_DEX}) n.flags[CRM_F_Z] = n.idxOne == 16'h0000;
               if (cmdOp inside {CRM_OP_INY, CRM_OP_DEY}) n.flags[CRM_F_Z] = n.idxTwo == 16'h0000;
            end else if ((r.xirqPend && !r.flags[CRM_F_X]) || (r.irqPend && !r.flags[CRM_F_I])) begin
               // The line interrupt wins when both are ready, since its mask is the stronger one.
               n.op = (r.xirqPend && !r.flags[CRM_F_X]) ? CRM_OP_NONMASKABLE_INTERRUPT_LINE : CRM_OP_IRQ;
               n.vec = (n.op == CRM_OP_NONMASKABLE_INTERRUPT_LINE) ? r.xirqVec : r.irqVec;
               if (n.op == CRM_OP_NONMASKABLE_INTERRUPT_LINE) n.xirqPend = 1'b0;
               else n.irqPend = 1'b0;
               n.frame = {r.flags, r.accB, r.accA, r.idxOne, r.idxTwo, r.progCnt};
               n.len = CRM_LEN_FRAME;
               n.cnt = 4'h0;
               n.mem = '{req: 1'b1, write: 1'b1, addr: r.stackPtr, wdata: r.progCnt[7:0]};
               n.st = CRM_S_PUSH;
            end
         end
         CRM_S_PUSH: begin
            if (memAck) begin
               n.stackPtr = r.stackPtr - 16'h0001;
               n.cnt = r.cnt + 4'h1;
               n.mem.addr = n.stackPtr;
               n.mem.wdata = r.frame[{n.cnt, 3'b000} +: 8];
               if (n.cnt == r.len) begin
                  n.mem.req = 1'b0;
                  n.st = CRM_S_IDLE;
                  if (r.op inside {CRM_OP_IRQ, CRM_OP_NONMASKABLE_INTERRUPT_LINE}) begin
                     n.flags[CRM_F_I] = 1'b1;
                     if (r.op == CRM_OP_NONMASKABLE_INTERRUPT_LINE) n.flags[CRM_F_X] = 1'b1;
                     n.mem = '{req: 1'b1, write: 1'b0, addr: r.vec, wdata: 8'h00};
                     n.st = CRM_S_VEC_HI;
                  end
               end
            end
         end
         CRM_S_PULL: begin
            if (memAck) begin
               n.stackPtr = r.stackPtr + 16'h0001;
               n.frame[{idx, 3'b000} +: 8] = memRdata;
               n.mem.addr = n.stackPtr + 16'h0001;
               n.cnt = r.cnt - 4'h1;
               if (r.cnt == 4'h0) begin
                  n.mem.req = 1'b0;
                  n.st = CRM_S_IDLE;
                  unique case (r.op)
                     CRM_OP_PULA: n.accA = n.frame[7:0];
                     CRM_OP_RTS: n.progCnt = n.frame[15:0];
                     default: begin
                        {n.flags, n.accB, n.accA, n.idxOne, n.idxTwo, n.progCnt} = n.frame;
                        n.flags[CRM_F_X] = n.frame[64 + CRM_F_X] & r.flags[CRM_F_X];
                     end
                  endcase
               end
            end
         end
         CRM_S_STORE: begin
            if (memAck) begin
               n.mem.req = 1'b0;
               n.st = CRM_S_IDLE;
            end
         end
         default: n.st = CRM_S_RST;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
         r.st <= CRM_S_RST;
         r.op <= CRM_OP_NOP;
         r.flags <= CRM_FLAG_RST;
      end else begin
         r <= n;
      end
   end

   a_reset_masks: assert property (@(posedge clk) $fell(rst) |->
      r.flags[CRM_F_I] && r.flags[CRM_F_X] && r.flags[CRM_F_S] && r.st == CRM_S_RST)
      else $error("Masks not set after reset.");
   // The sampled reset gates the vector checks, since the release edge itself still shows the reset state.
   a_reset_vector: assert property (@(posedge clk) disable iff (rst)
      r.st == CRM_S_RST && !rst && !bootMode && resetCause == CRM_CAUSE_WDOG |=> r.mem.addr == 16'hFFFA && r.mem.req)
      else $error("Wrong normal watchdog vector.");
   a_boot_vector: assert property (@(posedge clk) disable iff (rst)
      r.st == CRM_S_RST && !rst && bootMode && resetCause == CRM_CAUSE_POR |=> r.mem.addr == 16'hBFFE)
      else $error("Wrong boot reset vector.");
   a_push_step: assert property (@(posedge clk) disable iff (rst)
      r.st == CRM_S_PUSH && memAck |=> r.stackPtr == $past(r.stackPtr) - 16'h0001)
      else $error("Push did not decrement the stack pointer.");
   a_abx_sum: assert property (@(posedge clk) disable iff (rst)
      go && cmdOp == CRM_OP_ABX |=> r.idxOne == $past(r.idxOne) + {8'h00, $past(r.accB)} && $stable(r.flags))
      else $error("Index add wrong or flags moved.");
   a_tpa_copy: assert property (@(posedge clk) disable iff (rst)
      go && cmdOp == CRM_OP_TPA |=> r.accA == $past(r.flags) && $stable(r.accB))
      else $error("Flag transfer to accumulator wrong.");
   a_inx_zonly: assert property (@(posedge clk) disable iff (rst)
      go && cmdOp == CRM_OP_INX |=> (r.flags & 8'hFB) == ($past(r.flags) & 8'hFB)
      && r.flags[CRM_F_Z] == (r.idxOne == 16'h0000))
      else $error("Index step touched more than zero.");
   a_load_flags: assert property (@(posedge clk) disable iff (rst)
      go && cmdOp == CRM_OP_LDA |=> r.flags[CRM_F_N] == r.accA[7] && !r.flags[CRM_F_V]
      && r.flags[CRM_F_Z] == (r.accA == 8'h00))
      else $error("Load flags wrong.");
   a_half_carry: assert property (@(posedge clk) disable iff (rst)
      go && cmdOp == CRM_OP_ADDA |=> r.flags[CRM_F_H] == ($past(r.accA[4]) ^ $past(opByte[4]) ^ r.accA[4]))
      else $error("Half carry wrong.");
   a_xmask_clear: assert property (@(posedge clk) disable iff (rst)
      $fell(r.flags[CRM_F_X]) |-> $past(go && cmdOp == CRM_OP_TAP) || $past(r.st == CRM_S_PULL && r.op == CRM_OP_RTI))
      else $error("Line mask cleared by hardware.");
   a_stop_nop: assert property (@(posedge clk) disable iff (rst)
      go && cmdOp == CRM_OP_STOP && r.flags[CRM_F_S] |=> !r.stopped ##1 !r.stopped || go)
      else $error("Disabled stop still stopped.");
   a_mask_order: assert property (@(posedge clk) disable iff (rst)
      r.st == CRM_S_PUSH && r.op inside {CRM_OP_IRQ, CRM_OP_NONMASKABLE_INTERRUPT_LINE} && memAck && r.cnt == 4'h8 |=>
      r.flags[CRM_F_I] && r.st == CRM_S_VEC_HI && r.stackPtr == $past(r.stackPtr) - 16'h0001)
      else $error("Global mask not set at vector fetch.");

endmodule

// >>> crm_mem_model.sv
// Byte memory model that answers the CPU register model's memory requests.
// Assumes a request stands until memAck; each byte is answered one cycle later.
module crm_mem_model
   import crm_pkg::*;
(
   input wire logic clk,
   input wire crm_mem_req_t memOut,
   output logic memAck,
   output logic [7:0] memRdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:65535];
   initial begin
      memAck = 1'b0;
      for (int i = 0; i < 65536; i++) begin
         mem[i] = i[7:0] ^ i[15:8] ^ 8'h3C;
      end
   end
   always @(posedge clk) begin
      memAck <= memOut.req && !memAck;
      if (memOut.req && memAck && memOut.write) begin
         mem[memOut.addr] <= memOut.wdata;
      end
   end
   // Outside an answer the data lines show the inverse, so stale bytes are never taken.
   assign memRdata = memAck ? mem[memOut.addr] : ~mem[memOut.addr];
endmodule

// >>> tb_cpu_register_model.sv
// Self-checking bench for the CPU register model, driven over AXI4-Lite.
// Assumes the byte memory model on the far side and readies held high by the bench.
module tb_cpu_register_model import crm_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, bootMode = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic bready = 1'b1, rready = 1'b1, memAck, awready, wready, bvalid, arready, rvalid;
   crm_cause_t resetCause = CRM_CAUSE_POR;
   crm_mem_req_t memOut;
   logic [7:0] memRdata, awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, d;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp, r;
   logic [15:0] p;
   int err_count = 0, num_checks = 0;
   cpu_register_model uut (.clk(clk), .rst(rst), .bootMode(bootMode), .resetCause(resetCause),
      .memOut(memOut), .memAck(memAck), .memRdata(memRdata), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   crm_mem_model mem_i (.clk(clk), .memOut(memOut), .memAck(memAck), .memRdata(memRdata));
   function automatic logic [7:0] f(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3C;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
   endtask
   // Polling status keeps the bench free of any assumed command latency.
   task automatic idle();
      do rd(CRM_OFF_STAT);
      while (d[0] !== 1'b0);
   endtask
   task automatic cmd(input crm_op_t op, input logic [7:0] b = 8'h00, input logic [15:0] w = 16'h0000);
      wr(CRM_OFF_CMD, {w, b, 3'b000, op});
      idle();
   endtask
   task automatic flg(input int b, input logic e);
      rd(CRM_OFF_FLAG);
      chk(32'(d[b]), 32'(e));
   endtask
   task automatic do_rst(input logic m, input crm_cause_t c);
      rst <= 1'b1;
      bootMode <= m;
      resetCause <= c;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      idle();
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      forever #4 clk = ~clk;
   end
   initial begin
      #400000;
      err_count++;
      give_verdict();
   end
   initial begin
      @(posedge clk);
      for (int m = 0; m < 2; m++) begin
         for (int c = 0; c < 3; c++) begin
            do_rst(m[0], crm_cause_t'(c));
            p = (m[0] ? 16'hBFFE : 16'hFFFE) - 16'(2 * c);
            rd(CRM_OFF_STK);
            chk(32'(d[15:0]), 32'({f(p), f(p + 16'h0001)}));
            rd(CRM_OFF_FLAG);
            chk(32'(d[7:0]), 32'h00D0);
         end
      end
      cmd(CRM_OP_STOP);
      rd(CRM_OFF_STAT);
      chk(32'(d[1]), 32'h0000);
      cmd(CRM_OP_LDA, 8'h80);
      flg(CRM_F_N, 1'b1);
      cmd(CRM_OP_LDA, 8'h0F);
      cmd(CRM_OP_ADDA, 8'h01);
      flg(CRM_F_H, 1'b1);
      cmd(CRM_OP_ADDA, 8'hF0);
      flg(CRM_F_C, 1'b1);
      flg(CRM_F_Z, 1'b1);
      flg(CRM_F_H, 1'b0);
      cmd(CRM_OP_LDA, 8'h70);
      cmd(CRM_OP_ADDA, 8'h10);
      flg(CRM_F_V, 1'b1);
      cmd(CRM_OP_LDX, 8'h00, 16'h0203);
      cmd(CRM_OP_XGDX);
      rd(CRM_OFF_ACC);
      chk(32'(d[15:0]), 32'h0203);
      cmd(CRM_OP_LDX, 8'h00, 16'h1000);
      rd(CRM_OFF_FLAG);
      p = d[15:0];
      cmd(CRM_OP_ABX);
      rd(CRM_OFF_IDX);
      chk(32'(d[31:16]), 32'h1003);
      flg(CRM_F_Z, p[CRM_F_Z]);
      cmd(CRM_OP_STAX, 8'hF0);
      rd(CRM_OFF_FLAG);
      chk(32'(d[31:16]), 32'h10F3);
      chk(32'(mem_i.mem[16'h10F3]), 32'h0002);
      cmd(CRM_OP_LDS, 8'h00, 16'h0800);
      rd(CRM_OFF_STK);
      p = d[15:0];
      cmd(CRM_OP_JSR, 8'h00, 16'h4000);
      rd(CRM_OFF_STK);
      chk(d, {16'h07FE, 16'h4000});
      chk(32'({mem_i.mem[16'h07FF], mem_i.mem[16'h0800]}), 32'(p));
      cmd(CRM_OP_RTS);
      rd(CRM_OFF_STK);
      chk(d, {16'h0800, p});
      cmd(CRM_OP_NONMASKABLE_INTERRUPT_LINE, 8'h00, 16'h5000);
      rd(CRM_OFF_STAT);
      chk(32'(d[3]), 32'h0001);
      cmd(CRM_OP_LDA, 8'h00);
      cmd(CRM_OP_TAP);
      repeat (4) @(posedge clk);
      idle();
      rd(CRM_OFF_STK);
      chk(d, {16'h07F7, f(16'h5000), f(16'h5001)});
      chk(32'(mem_i.mem[16'h07F8]), 32'h0000);
      flg(CRM_F_X, 1'b1);
      flg(CRM_F_I, 1'b1);
      cmd(CRM_OP_TPA);
      rd(CRM_OFF_ACC);
      chk(32'(d[15:8]), 32'h0050);
      cmd(CRM_OP_RTI);
      rd(CRM_OFF_STK);
      chk(d, {16'h0800, p});
      flg(CRM_F_X, 1'b0);
      cmd(CRM_OP_LDX, 8'h00, 16'hFFFF);
      cmd(CRM_OP_INX);
      flg(CRM_F_Z, 1'b1);
      flg(CRM_F_N, 1'b1);
      cmd(CRM_OP_LDX, 8'h00, 16'h0C0B);
      cmd(CRM_OP_XGDX);
      cmd(CRM_OP_MUL);
      rd(CRM_OFF_ACC);
      chk(32'(d[15:0]), 32'h0084);
      flg(CRM_F_C, 1'b1);
      cmd(CRM_OP_LDA, 8'h0C);
      cmd(CRM_OP_ABA);
      flg(CRM_F_H, 1'b1);
      flg(CRM_F_C, 1'b0);
      cmd(CRM_OP_CMPA, 8'hA0);
      flg(CRM_F_C, 1'b1);
      rd(CRM_OFF_ACC);
      chk(32'(d[15:8]), 32'h0090);
      cmd(CRM_OP_PSHA);
      cmd(CRM_OP_LDA, 8'h00);
      cmd(CRM_OP_PULA);
      rd(CRM_OFF_STK);
      chk(32'(d[31:16]), 32'h0800);
      chk(32'(mem_i.mem[16'h0800]), 32'h0090);
      rd(CRM_OFF_ACC);
      chk(32'(d[15:8]), 32'h0090);
      flg(CRM_F_Z, 1'b1);
      cmd(CRM_OP_LDY, 8'h00, 16'h2000);
      cmd(CRM_OP_ABY);
      cmd(CRM_OP_STAY, 8'h10);
      rd(CRM_OFF_IDX);
      chk(32'(d[15:0]), 32'h2084);
      chk(32'(mem_i.mem[16'h2094]), 32'h0090);
      cmd(CRM_OP_IRQ, 8'h00, 16'h6000);
      rd(CRM_OFF_STK);
      chk(d, {16'h07F7, f(16'h6000), f(16'h6001)});
      flg(CRM_F_I, 1'b1);
      flg(CRM_F_X, 1'b0);
      cmd(CRM_OP_STOP);
      rd(CRM_OFF_STAT);
      chk(32'(d[1]), 32'h0001);
      wr(CRM_OFF_ACC, 32'h0000_0000);
      chk(32'(r), 32'(CRM_RESP_SLVERR));
      rd(8'h20);
      chk(32'(r), 32'(CRM_RESP_DECERR));
      give_verdict();
   end
endmodule
